//--- shared/bil_params.svh
// Timing, layout and reset constants for the boot image loader
`ifndef BIL_PARAMS_SVH
`define BIL_PARAMS_SVH

// ==========================================================
// Timing
`define BIL_CLK_NS 40
`define BIL_RST_MIN_NS 15000
`define BIL_RST_CYC ((`BIL_RST_MIN_NS + `BIL_CLK_NS - 1) / `BIL_CLK_NS)

// ==========================================================
// Security register and image layout
`define BIL_SEC_BOOT_BIT 5
`define BIL_SEC_RST 32'h00000000
`define BIL_SEC_ROW 11'h7ff
`define BIL_IMG_ROW 11'h000
`define BIL_RAM_BASE 16'h0000

// ==========================================================
// Check word
`define BIL_BYPASS 32'h0d15ab1e
`define BIL_CRC_POLY 32'hedb88320
`define BIL_CRC_INIT 32'hffffffff

// ==========================================================
// Buffering
`define BIL_FIFO_DEPTH 4

`endif

//--- shared/bil_pkg.sv
// Types shared by the boot image loader modules
package bil_pkg;
  typedef logic [31:0] bil_word_t;
  typedef logic [10:0] bil_otp_addr_t;
  typedef logic [15:0] bil_ram_addr_t;
  typedef enum logic [3:0] {
    ST_RST_WAIT,
    ST_SEC,
    ST_GAP,
    ST_SIZE,
    ST_BODY,
    ST_CHECK,
    ST_RUN,
    ST_FAIL
  } bil_state_t;
endpackage : bil_pkg

//--- shared/bil_stream_if.sv
// Word stream with valid and ready between loader modules
`timescale 1ns/1ps
interface bil_stream_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bil_stream_if

//--- hw/bil_fifo.sv
// Word FIFO between the image source and the loader
`timescale 1ns/1ps
`include "bil_params.svh"
module bil_fifo #(
  parameter int W = 32,
  parameter int D = `BIL_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic flush_in,
  bil_stream_if.snk in_if,
  bil_stream_if.src out_if
);
  localparam int AW = $clog2(D);

  // ==========================================================
  // Storage and pointers
  logic [W-1:0] mem_r [D];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push = in_if.valid && !full;
  wire pop = out_if.ready && !empty;

  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_if.data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else if (flush_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_r + (AW+1)'(push);
      rd_r <= rd_r + (AW+1)'(pop);
    end
  end
endmodule : bil_fifo

//--- hw/bil_word_src.sv
// Fetches image words from the OTP array or the flash byte stream
`timescale 1ns/1ps
`include "bil_params.svh"
module bil_word_src
  import bil_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic otp_mode_in,
  input wire bil_otp_addr_t base_in,
  bil_stream_if.src out_if,
  output logic otp_rd_out,
  output bil_otp_addr_t otp_addr_out,
  input wire bil_word_t otp_data_in,
  input wire logic otp_valid_in,
  output logic flash_sel_out,
  input wire logic [7:0] flash_byte_in,
  input wire logic flash_valid_in,
  output logic flash_ready_out
);
  // ==========================================================
  // Word holding and handshakes
  bil_word_t word_r;
  logic have_r;
  logic busy_r;
  logic [1:0] bcnt_r;
  bil_otp_addr_t addr_r;

  wire issue = run_in && otp_mode_in && !busy_r && !have_r;
  wire otp_ret = busy_r && otp_valid_in && run_in;
  wire fl_take = flash_ready_out && flash_valid_in;
  wire pop = out_if.valid && out_if.ready;

  assign otp_rd_out = issue;
  assign otp_addr_out = addr_r;
  assign flash_sel_out = run_in && !otp_mode_in;
  assign flash_ready_out = flash_sel_out && !have_r;
  assign out_if.valid = have_r && run_in;
  assign out_if.data = word_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_r <= 1'b0;
    end else if (issue) begin
      busy_r <= 1'b1;
    end else if (otp_valid_in) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_r <= `BIL_IMG_ROW;
      have_r <= 1'b0;
      bcnt_r <= 2'h0;
      word_r <= '0;
    end else if (!run_in) begin
      addr_r <= base_in;
      have_r <= 1'b0;
      bcnt_r <= 2'h0;
    end else begin
      if (issue) begin
        addr_r <= addr_r + 11'h001;
      end
      if (otp_ret) begin
        word_r <= otp_data_in;
        have_r <= 1'b1;
      end else if (fl_take) begin
        word_r[8*bcnt_r +: 8] <= flash_byte_in;
        bcnt_r <= bcnt_r + 2'h1;
        have_r <= (bcnt_r == 2'h3);
      end else if (pop) begin
        have_r <= 1'b0;
      end
    end
  end
endmodule : bil_word_src

//--- hw/bil_boot_loader.sv
// Boot sequencer: reset hold, source select, image copy and check
`timescale 1ns/1ps
`include "bil_params.svh"
module bil_boot_loader
  import bil_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  output logic GPIO_PD_OUT,
  output logic CORE_RST_B_OUT,
  output bil_ram_addr_t START_ADDR_OUT,
  output logic BOOT_DONE_OUT,
  output logic BOOT_FAIL_OUT,
  output bil_word_t SEC_REG_OUT,
  output logic OTP_RD_OUT,
  output bil_otp_addr_t OTP_ADDR_OUT,
  input wire bil_word_t OTP_DATA_IN,
  input wire logic OTP_VALID_IN,
  output logic FLASH_SEL_OUT,
  input wire logic [7:0] FLASH_BYTE_IN,
  input wire logic FLASH_VALID_IN,
  output logic FLASH_READY_OUT,
  output logic RAM_WE_OUT,
  output bil_ram_addr_t RAM_ADDR_OUT,
  output bil_word_t RAM_WDATA_OUT,
  input wire logic RAM_READY_IN
);
  localparam logic [8:0] RST_LAST = 9'(`BIL_RST_CYC - 1);

  // ==========================================================
  // CRC over one byte, least significant bit first
  function automatic bil_word_t bil_crc_byte(input bil_word_t crc, input logic [7:0] data);
    bil_word_t c;
    c = crc ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `BIL_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : bil_crc_byte

  // ==========================================================
  // CRC over one little-endian word, low byte first
  function automatic bil_word_t bil_crc_word(input bil_word_t crc, input bil_word_t data);
    bil_word_t c;
    c = crc;
    for (int b = 0; b < 4; b++) begin
      c = bil_crc_byte(c, data[8*b +: 8]);
    end
    return c;
  endfunction : bil_crc_word

  // ==========================================================
  // State
  bil_state_t state_r;
  bil_state_t state_nxt;
  logic [8:0] rst_cnt_r;
  bil_word_t sec_r;
  bil_word_t left_r;
  bil_ram_addr_t addr_r;
  bil_word_t crc_r;
  logic pd_r;
  logic we_r;
  bil_word_t wdata_r;

  bil_stream_if src_s ();
  bil_stream_if fifo_s ();

  // ==========================================================
  // State decode
  wire st_wait = (state_r == ST_RST_WAIT);
  wire st_sec = (state_r == ST_SEC);
  wire st_size = (state_r == ST_SIZE);
  wire st_body = (state_r == ST_BODY);
  wire st_check = (state_r == ST_CHECK);
  wire st_run = (state_r == ST_RUN);
  wire st_fail = (state_r == ST_FAIL);

  // ==========================================================
  // Source selection and stream control
  wire src_run = st_sec || st_size || st_body || st_check;
  wire sec_boot = sec_r[`BIL_SEC_BOOT_BIT];
  wire otp_mode = st_sec || sec_boot;
  // Security row is loaded while waiting so the single read goes to it
  wire bil_otp_addr_t src_base = (st_wait || st_sec) ? `BIL_SEC_ROW : `BIL_IMG_ROW;
  // Security word leaves at the source so no second row is requested
  wire sec_take = st_sec && src_s.valid && src_s.ready;
  wire take = fifo_s.valid && fifo_s.ready;
  wire size_take = st_size && take;
  wire body_take = st_body && take;
  wire bil_word_t word = fifo_s.data;
  wire rst_done = (rst_cnt_r == RST_LAST);
  wire last_body = (left_r == 32'h00000001);

  // ==========================================================
  // Next values and check
  wire [8:0] rst_cnt_nxt = rst_cnt_r + 9'h001;
  wire bil_word_t left_nxt = left_r - 32'h00000001;
  wire bil_ram_addr_t addr_nxt = addr_r + 16'h0001;
  wire bil_word_t crc_nxt = bil_crc_word(size_take ? `BIL_CRC_INIT : crc_r, word);
  wire is_bypass = (word == `BIL_BYPASS);
  wire bil_word_t crc_result = ~crc_r;
  wire crc_ok = is_bypass || (word == crc_result);

  assign fifo_s.ready = st_size || st_check || (st_body && RAM_READY_IN);

  bil_word_src u_src (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .run_in(src_run),
    .otp_mode_in(otp_mode),
    .base_in(src_base),
    .out_if(src_s),
    .otp_rd_out(OTP_RD_OUT),
    .otp_addr_out(OTP_ADDR_OUT),
    .otp_data_in(OTP_DATA_IN),
    .otp_valid_in(OTP_VALID_IN),
    .flash_sel_out(FLASH_SEL_OUT),
    .flash_byte_in(FLASH_BYTE_IN),
    .flash_valid_in(FLASH_VALID_IN),
    .flash_ready_out(FLASH_READY_OUT)
  );

  bil_fifo #(
    .W(32),
    .D(`BIL_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_b_in(RST_B_IN),
    .flush_in(!src_run),
    .in_if(src_s),
    .out_if(fifo_s)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RST_WAIT: begin
        if (rst_done) begin
          state_nxt = ST_SEC;
        end
      end
      ST_SEC: begin
        if (sec_take) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        state_nxt = ST_SIZE;
      end
      ST_SIZE: begin
        if (take) begin
          state_nxt = (word == 32'h00000000) ? ST_CHECK : ST_BODY;
        end
      end
      ST_BODY: begin
        if (take && last_body) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (take) begin
          state_nxt = crc_ok ? ST_RUN : ST_FAIL;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      ST_FAIL: begin
        state_nxt = ST_FAIL;
      end
      default: begin
        state_nxt = ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r <= ST_RST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_cnt_r <= 9'h000;
    end else if (!rst_done) begin
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pd_r <= 1'b1;
    end else begin
      pd_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sec_r <= `BIL_SEC_RST;
    end else if (sec_take) begin
      sec_r <= src_s.data;
    end
  end

  // ==========================================================
  // Image copy and CRC
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      crc_r <= `BIL_CRC_INIT;
    end else if (size_take || body_take) begin
      crc_r <= crc_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      left_r <= '0;
    end else if (size_take) begin
      left_r <= word;
    end else if (body_take) begin
      left_r <= left_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      addr_r <= `BIL_RAM_BASE;
    end else if (st_size) begin
      addr_r <= `BIL_RAM_BASE;
    end else if (we_r) begin
      addr_r <= addr_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      we_r <= 1'b0;
    end else begin
      we_r <= body_take;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wdata_r <= '0;
    end else if (body_take) begin
      wdata_r <= word;
    end
  end

  // ==========================================================
  // Outputs
  assign GPIO_PD_OUT = pd_r;
  assign CORE_RST_B_OUT = st_run;
  assign START_ADDR_OUT = `BIL_RAM_BASE;
  assign BOOT_DONE_OUT = st_run;
  assign BOOT_FAIL_OUT = st_fail;
  assign SEC_REG_OUT = sec_r;
  assign RAM_WE_OUT = we_r;
  assign RAM_ADDR_OUT = addr_r;
  assign RAM_WDATA_OUT = wdata_r;
endmodule : bil_boot_loader

//--- tb/bil_boot_loader_assertions.sv
// Port assertions for the boot image loader
`timescale 1ns/1ps
module bil_chk
  import bil_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic GPIO_PD_OUT,
  input wire logic CORE_RST_B_OUT,
  input wire bil_ram_addr_t START_ADDR_OUT,
  input wire logic BOOT_DONE_OUT,
  input wire logic BOOT_FAIL_OUT,
  input wire bil_word_t SEC_REG_OUT,
  input wire logic OTP_RD_OUT,
  input wire bil_otp_addr_t OTP_ADDR_OUT,
  input wire logic FLASH_SEL_OUT,
  input wire logic RAM_WE_OUT,
  input wire bil_ram_addr_t RAM_ADDR_OUT
);
  logic [15:0] wr_r;
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_r <= 16'h0000;
    end else begin
      wr_r <= wr_r + {15'h0000, RAM_WE_OUT};
    end
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // ==========================================================
  // Assertions
  rst_hold_a: assert property (disable iff (1'b0) !RST_B_IN |-> GPIO_PD_OUT && !CORE_RST_B_OUT)
    else $error("reset outputs wrong");
  pd_release_a: assert property ($rose(RST_B_IN) |=> !GPIO_PD_OUT)
    else $error("pull-down kept after reset");
  boot_delay_a: assert property ($rose(RST_B_IN) |-> ##[370:1000] OTP_RD_OUT)
    else $error("boot start not in time");
  otp_row_a: assert property (OTP_RD_OUT && !SEC_REG_OUT[5] |-> OTP_ADDR_OUT == 11'h7ff)
    else $error("image read from otp in flash mode");
  flash_sel_a: assert property (FLASH_SEL_OUT |-> !SEC_REG_OUT[5] && !OTP_RD_OUT)
    else $error("flash used in otp mode");
  wr_addr_a: assert property (RAM_WE_OUT |-> RAM_ADDR_OUT == wr_r)
    else $error("ram address out of order");
  no_wr_end_a: assert property (BOOT_DONE_OUT || BOOT_FAIL_OUT |-> !RAM_WE_OUT)
    else $error("ram write after load");
  fail_hold_a: assert property (BOOT_FAIL_OUT |=> BOOT_FAIL_OUT && !CORE_RST_B_OUT && !BOOT_DONE_OUT)
    else $error("failure not held");
  run_start_a: assert property (CORE_RST_B_OUT |-> BOOT_DONE_OUT && START_ADDR_OUT == 16'h0000)
    else $error("core started wrongly");
  done_c: cover property (BOOT_DONE_OUT);
  fail_c: cover property (BOOT_FAIL_OUT);
  otp_c: cover property (RAM_WE_OUT && SEC_REG_OUT[5]);
endmodule : bil_chk

bind bil_boot_loader bil_chk u_chk (.CLK_SYS_IN, .RST_B_IN, .GPIO_PD_OUT, .CORE_RST_B_OUT, .START_ADDR_OUT,
  .BOOT_DONE_OUT, .BOOT_FAIL_OUT, .SEC_REG_OUT, .OTP_RD_OUT, .OTP_ADDR_OUT, .FLASH_SEL_OUT, .RAM_WE_OUT,
  .RAM_ADDR_OUT);

//--- tb/bil_src_model.sv
// Image source model: OTP rows and flash byte stream
`timescale 1ns/1ps
module bil_src_model
  import bil_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic otp_rd_in,
  input wire bil_otp_addr_t otp_addr_in,
  output bil_word_t otp_data_out,
  output logic otp_valid_out,
  input wire logic flash_sel_in,
  input wire logic flash_ready_in,
  output logic [7:0] flash_byte_out,
  output logic flash_valid_out
);
  bil_word_t img [0:15];
  bil_word_t sec;
  logic slow;
  bil_otp_addr_t a_r;
  logic [1:0] cnt_r;
  logic [5:0] bi_r;
  logic t_r;
  // ==========================================================
  // OTP: security word at the top row, image from row 0
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 2'h0;
      otp_valid_out <= 1'b0;
      otp_data_out <= 32'h0;
    end else begin
      otp_valid_out <= 1'b0;
      otp_data_out <= ~otp_data_out;
      if (cnt_r != 2'h0) cnt_r <= cnt_r - 2'h1;
      if (otp_rd_in) begin
        a_r <= otp_addr_in;
        cnt_r <= slow ? 2'h3 : 2'h1;
      end else if (cnt_r == 2'h1) begin
        otp_valid_out <= 1'b1;
        otp_data_out <= (a_r == 11'h7ff) ? sec : img[a_r[3:0]];
      end
    end
  end
  // ==========================================================
  // Flash: image bytes, least significant first
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bi_r <= 6'h0;
      t_r <= 1'b0;
    end else begin
      t_r <= ~t_r;
      if (!flash_sel_in) bi_r <= 6'h0;
      else if (flash_valid_out && flash_ready_in) bi_r <= bi_r + 6'h1;
    end
  end
  assign flash_valid_out = flash_sel_in && !(slow && t_r);
  assign flash_byte_out = flash_valid_out ? img[bi_r[5:2]][{bi_r[1:0], 3'h0} +: 8] : {8{t_r}};
endmodule : bil_src_model

//--- tb/tb_bil_boot_loader.sv
// Self-checking bench for the boot image loader
`timescale 1ns/1ps
`include "bil_params.svh"
module tb_bil_boot_loader
  import bil_pkg::*;
;
  logic CLK_SYS_IN = 1'b0;
  logic RST_B_IN = 1'b1;
  logic GPIO_PD_OUT, CORE_RST_B_OUT, BOOT_DONE_OUT, BOOT_FAIL_OUT, OTP_RD_OUT, OTP_VALID_IN;
  logic FLASH_SEL_OUT, FLASH_VALID_IN, FLASH_READY_OUT, RAM_WE_OUT, RAM_READY_IN = 1'b1;
  bil_ram_addr_t START_ADDR_OUT, RAM_ADDR_OUT;
  bil_word_t SEC_REG_OUT, OTP_DATA_IN, RAM_WDATA_OUT;
  bil_otp_addr_t OTP_ADDR_OUT;
  logic [7:0] FLASH_BYTE_IN;
  bil_word_t mem [0:15];
  int nwr, n_mismatch, n_compared;
  logic sel_seen, stall = 1'b0;
  bil_boot_loader dut (.CLK_SYS_IN, .RST_B_IN, .GPIO_PD_OUT, .CORE_RST_B_OUT, .START_ADDR_OUT, .BOOT_DONE_OUT,
    .BOOT_FAIL_OUT, .SEC_REG_OUT, .OTP_RD_OUT, .OTP_ADDR_OUT, .OTP_DATA_IN, .OTP_VALID_IN, .FLASH_SEL_OUT,
    .FLASH_BYTE_IN, .FLASH_VALID_IN, .FLASH_READY_OUT, .RAM_WE_OUT, .RAM_ADDR_OUT, .RAM_WDATA_OUT, .RAM_READY_IN);
  bil_src_model src (.clk_in(CLK_SYS_IN), .rst_b_in(RST_B_IN), .otp_rd_in(OTP_RD_OUT), .otp_addr_in(OTP_ADDR_OUT),
    .otp_data_out(OTP_DATA_IN), .otp_valid_out(OTP_VALID_IN), .flash_sel_in(FLASH_SEL_OUT),
    .flash_ready_in(FLASH_READY_OUT), .flash_byte_out(FLASH_BYTE_IN), .flash_valid_out(FLASH_VALID_IN));
  // ==========================================================
  // Clock, RAM stall and monitor
  initial begin
    forever #20 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  always @(negedge CLK_SYS_IN) RAM_READY_IN <= !stall || !RAM_READY_IN;
  always @(posedge CLK_SYS_IN) begin
    if (RAM_WE_OUT === 1'b1) begin
      mem[RAM_ADDR_OUT[3:0]] <= RAM_WDATA_OUT;
      nwr <= nwr + 1;
    end
    if (FLASH_SEL_OUT === 1'b1) sel_seen <= 1'b1;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(string name, bil_word_t e, bil_word_t g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  function automatic bil_word_t crc_of(int n);
    bil_word_t c = `BIL_CRC_INIT;
    for (int i = 0; i < n * 32; i++) c = (c[0] ^ src.img[i / 32][i % 32]) ? (c >> 1) ^ `BIL_CRC_POLY : c >> 1;
    return ~c;
  endfunction : crc_of
  task automatic run(bit sec, int s, int mode, bit slow);
    int n = 0;
    src.sec = {26'h0, sec, 5'h0};
    src.slow = slow;
    stall = slow;
    for (int i = 0; i < 16; i++) src.img[i] = 32'h9e3779b9 * (i + 1);
    src.img[0] = s;
    src.img[s + 1] = (mode == 1) ? `BIL_BYPASS : crc_of(s + 1) ^ (mode == 2);
    @(negedge CLK_SYS_IN);
    RST_B_IN = 1'b0;
    nwr = 0;
    sel_seen = 1'b0;
    repeat (10) @(negedge CLK_SYS_IN);
    chk("pull_down", 1, GPIO_PD_OUT);
    chk("core_reset", 0, CORE_RST_B_OUT);
    RST_B_IN = 1'b1;
    while (OTP_RD_OUT !== 1'b1 && n < 4000) begin
      @(negedge CLK_SYS_IN);
      n++;
    end
    chk("boot_delay", 1, n >= 370 && n <= 3750);
    chk("sec_row", 11'h7ff, OTP_ADDR_OUT);
    repeat (80) @(negedge CLK_SYS_IN);
    chk("sec_reg", src.sec, SEC_REG_OUT);
    n = 0;
    while (BOOT_DONE_OUT !== 1'b1 && BOOT_FAIL_OUT !== 1'b1 && n < 2000) begin
      @(negedge CLK_SYS_IN);
      n++;
    end
    repeat (30) @(negedge CLK_SYS_IN);
    chk("ram_count", s, nwr);
    for (int i = 0; i < s; i++) chk("ram_word", src.img[i + 1], mem[i]);
    chk("start_addr", 0, START_ADDR_OUT);
  endtask : run
  // ==========================================================
  // Scenarios
  task automatic t_flash_crc;
    run(0, 5, 0, 1);
    chk("done", 1, BOOT_DONE_OUT);
    chk("core_run", 1, CORE_RST_B_OUT);
    chk("flash_used", 1, sel_seen);
    $display("test flash_crc ended");
  endtask : t_flash_crc
  task automatic t_bypass;
    run(0, 8, 1, 1);
    chk("done", 1, BOOT_DONE_OUT);
    $display("test bypass ended");
  endtask : t_bypass
  task automatic t_bad_crc;
    run(0, 3, 2, 0);
    chk("fail", 1, BOOT_FAIL_OUT);
    chk("core_held", 0, CORE_RST_B_OUT);
    $display("test bad_crc ended");
  endtask : t_bad_crc
  task automatic t_otp_boot;
    run(1, 4, 0, 1);
    chk("done", 1, BOOT_DONE_OUT);
    chk("flash_used", 0, sel_seen);
    $display("test otp_boot ended");
  endtask : t_otp_boot
  task automatic t_empty;
    run(0, 0, 0, 0);
    chk("done", 1, BOOT_DONE_OUT);
    $display("test empty ended");
  endtask : t_empty
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    t_flash_crc();
    t_bypass();
    t_bad_crc();
    t_otp_boot();
    t_empty();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS_IN);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_bil_boot_loader
